// File: hdl/phy_ctrl_pkg.sv
// Constants, register map and field layout for the PHY sleep/wake and basic control register bank.
// Assumes a 250 MHz device clock and an Avalon-MM host with byte addresses.
package phy_ctrl_pkg;

    // Bus geometry; byte address is four times the register index.
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;

    // Register indices.
    localparam logic [7:0] IDX_POWER_MGMT = 8'hd4;
    localparam logic [7:0] IDX_SLEEP_WAKE = 8'hd6;
    localparam logic [7:0] IDX_PHY_RESET = 8'hd8;
    localparam logic [7:0] IDX_BASIC_CTRL = 8'he4;
    localparam logic [7:0] IDX_PORT_CTRL_ALIAS = 8'hf8;
    localparam logic [7:0] IDX_PORT_STATUS_ALIAS = 8'hfa;

    // Sleep/wake timing fields and reset values.
    localparam int WAKE_LSB = 8;
    localparam int SLEEP_LSB = 0;
    localparam logic [7:0] WAKE_RST = 8'h08;
    localparam logic [7:0] SLEEP_RST = 8'h0c;

    // Power management fields.
    localparam int PM_MODE_LSB = 0;
    localparam int PM_AUTO_WAKE = 7;
    localparam logic [1:0] PM_MODE_RST = 2'h0;
    localparam logic [1:0] PM_ENERGY_DETECT = 2'h1;

    // PHY reset bit.
    localparam int PR_RESET = 0;

    // Basic control bit positions, storage mask and reset value.
    localparam int BC_LOOPBACK = 14;
    localparam int BC_FORCE_100 = 13;
    localparam int BC_AUTONEG_EN = 12;
    localparam int BC_AUTONEG_RESTART = 9;
    localparam int BC_FULL_DUPLEX = 8;
    localparam int BC_XOVER_ALG = 5;
    localparam int BC_FORCE_MDIX = 4;
    localparam int BC_MDIX_OFF = 3;
    localparam int BC_TX_OFF = 1;
    localparam int BC_LED_OFF = 0;
    localparam logic [15:0] BC_MASK = 16'h733b;
    localparam logic [15:0] BC_RST = 16'h3120;

    // Alias positions in the port control view.
    localparam int PC_FORCE_100 = 6;
    localparam int PC_AUTONEG_EN = 7;
    localparam int PC_AUTONEG_RESTART = 13;
    localparam int PC_FULL_DUPLEX = 5;
    localparam int PC_FORCE_MDIX = 9;
    localparam int PC_MDIX_OFF = 10;
    localparam int PC_TX_OFF = 14;
    localparam int PC_LED_OFF = 15;

    // Alias position in the port status view.
    localparam int PS_XOVER_ALG = 15;

    // Timing units as printed and derived cycle counts at the clock rate.
    localparam int CLK_MHZ = 250;
    localparam int WAKE_UNIT_MS = 16;
    localparam int SLEEP_UNIT_S = 1;
    localparam int WAKE_UNIT_CYC = WAKE_UNIT_MS * CLK_MHZ * 1000;
    localparam int SLEEP_UNIT_CYC = SLEEP_UNIT_S * CLK_MHZ * 1000000;

    // Power state, one-hot.
    typedef enum logic [1:0]
    {
        ST_NORMAL = 2'h1,
        ST_LOW_POWER = 2'h2
    } power_state_t;

endpackage : phy_ctrl_pkg

// File: hdl/phy_sleep_wake_and_basic_control.sv
// Register bank for PHY power timing, PHY reset and the basic port control register with its aliases.
// Assumes an Avalon-MM master that holds each request until waitrequest is sampled low.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps

module phy_sleep_wake_and_basic_control
    import phy_ctrl_pkg::*;
#(
    parameter int unsigned WAKE_UNIT_CYCLES = WAKE_UNIT_CYC,
    parameter int unsigned SLEEP_UNIT_CYCLES = SLEEP_UNIT_CYC
)
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [ADDR_W-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [DATA_W-1:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [DATA_W-1:0] o_readdata,
    output logic o_waitrequest,
    input wire logic i_energy_detected,
    output logic o_low_power,
    output logic o_phy_reset,
    output logic o_host_loopback,
    output logic o_force_100,
    output logic o_autoneg_en,
    output logic o_autoneg_restart,
    output logic o_full_duplex,
    output logic o_crossover_algorithm_select,
    output logic o_force_mdix,
    output logic o_mdix_off,
    output logic o_tx_off,
    output logic o_led_off
);

    // Matches a byte address against a register index.
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        hit = (addr == {idx, 2'h0});
    endfunction : hit

    // Replaces the bytes of a 16-bit register selected by the low byte enables.
    function automatic logic [REG_W-1:0] merge16(input logic [REG_W-1:0] old_v,
                                                 input logic [REG_W-1:0] new_v,
                                                 input logic [1:0] be);
        merge16 = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
    endfunction : merge16

    logic ack_q; // High in the one cycle in which the pending request is answered.
    logic req; // A read or write is being presented.
    logic wr_fire; // Write takes effect at this edge.
    logic rd_fire; // Read completes at this edge.
    logic [DATA_W-1:0] readdata_q; // Read data held for the master.
    logic [REG_W-1:0] rd_mux; // Selected register view.
    logic [7:0] wake_time_q; // Wake-up period in 16 ms units.
    logic [7:0] sleep_time_q; // Go-sleep period in 1 s units.
    logic [1:0] pm_mode_q; // Power management mode.
    logic auto_wake_q; // Automatic wake-up enable.
    logic [REG_W-1:0] bc_q; // Shared basic control storage.
    logic [REG_W-1:0] bc_d; // Next value of the basic control storage.
    logic [REG_W-1:0] pc_view; // Basic control bits seen in port control layout.
    logic [REG_W-1:0] ps_view; // Basic control bits seen in port status layout.
    logic [REG_W-1:0] wdata16; // Low half of the write data.
    logic phy_reset_q; // One-cycle PHY reset pulse.
    power_state_t state_q; // Current power state.
    logic [31:0] prescale_q; // Cycles within the current time unit.
    logic [7:0] units_q; // Whole units elapsed with the condition held.
    logic [31:0] unit_cyc; // Cycles per unit for the current state.
    logic [7:0] target; // Units required for the current state.
    logic cond; // Energy condition tracked in the current state.
    logic armed; // Timing is active for the current state.
    logic go; // Period has elapsed: change state.

    assign req = i_read | i_write;
    assign o_waitrequest = req & ~ack_q;
    assign wr_fire = i_write & ack_q;
    assign rd_fire = i_read & ack_q;
    assign wdata16 = i_writedata[REG_W-1:0];
    assign o_readdata = readdata_q;

    // Answers every request one cycle after it appears, then drops the answer.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            ack_q <= 1'b0;
        else
            ack_q <= req & ~ack_q;
    end

    // Alias views share the basic control flops.
    always_comb
    begin
        pc_view = '0;
        pc_view[PC_FORCE_100] = bc_q[BC_FORCE_100];
        pc_view[PC_AUTONEG_EN] = bc_q[BC_AUTONEG_EN];
        pc_view[PC_AUTONEG_RESTART] = bc_q[BC_AUTONEG_RESTART];
        pc_view[PC_FULL_DUPLEX] = bc_q[BC_FULL_DUPLEX];
        pc_view[PC_FORCE_MDIX] = bc_q[BC_FORCE_MDIX];
        pc_view[PC_MDIX_OFF] = bc_q[BC_MDIX_OFF];
        pc_view[PC_TX_OFF] = bc_q[BC_TX_OFF];
        pc_view[PC_LED_OFF] = bc_q[BC_LED_OFF];
        ps_view = '0;
        ps_view[PS_XOVER_ALG] = bc_q[BC_XOVER_ALG];
    end

    // Selects the register view for a read; unmapped addresses and the reset register read zero.
    always_comb
    begin
        rd_mux = '0;
        if (hit(i_address, IDX_SLEEP_WAKE))
            rd_mux = {wake_time_q, sleep_time_q};
        else if (hit(i_address, IDX_POWER_MGMT))
        begin
            rd_mux[PM_AUTO_WAKE] = auto_wake_q;
            rd_mux[PM_MODE_LSB +: 2] = pm_mode_q;
        end
        else if (hit(i_address, IDX_BASIC_CTRL))
            rd_mux = bc_q;
        else if (hit(i_address, IDX_PORT_CTRL_ALIAS))
            rd_mux = pc_view;
        else if (hit(i_address, IDX_PORT_STATUS_ALIAS))
            rd_mux = ps_view;
        else
            rd_mux = '0; // The reset bit is write-only and reads as zero.
    end

    // Captures read data in the cycle before it is presented.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            readdata_q <= '0;
        else if (i_read & ~ack_q)
            readdata_q <= {{(DATA_W-REG_W){1'b0}}, rd_mux};
    end

    // Sleep/wake timing register; zero counts are the host's to avoid.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            wake_time_q <= WAKE_RST;
            sleep_time_q <= SLEEP_RST;
        end
        else if (wr_fire && hit(i_address, IDX_SLEEP_WAKE))
        begin
            if (i_byteenable[1])
                wake_time_q <= wdata16[WAKE_LSB +: 8];
            if (i_byteenable[0])
                sleep_time_q <= wdata16[SLEEP_LSB +: 8];
        end
    end

    // Power management mode and automatic wake enable.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pm_mode_q <= PM_MODE_RST;
            auto_wake_q <= 1'b0;
        end
        else if (wr_fire && hit(i_address, IDX_POWER_MGMT) && i_byteenable[0])
        begin
            pm_mode_q <= wdata16[PM_MODE_LSB +: 2];
            auto_wake_q <= wdata16[PM_AUTO_WAKE];
        end
    end

    // PHY reset pulse: one cycle per write of one, never stored.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            phy_reset_q <= 1'b0;
        else
            phy_reset_q <= wr_fire & hit(i_address, IDX_PHY_RESET) & i_byteenable[0]
                           & wdata16[PR_RESET];
    end
    assign o_phy_reset = phy_reset_q;

    // Next basic control value from a direct write or from either alias.
    always_comb
    begin
        logic [REG_W-1:0] m;
        m = '0;
        bc_d = bc_q;
        if (wr_fire && hit(i_address, IDX_BASIC_CTRL))
            bc_d = merge16(bc_q, wdata16, i_byteenable[1:0]) & BC_MASK;
        else if (wr_fire && hit(i_address, IDX_PORT_CTRL_ALIAS))
        begin
            m = merge16(pc_view, wdata16, i_byteenable[1:0]);
            bc_d[BC_FORCE_100] = m[PC_FORCE_100];
            bc_d[BC_AUTONEG_EN] = m[PC_AUTONEG_EN];
            bc_d[BC_AUTONEG_RESTART] = m[PC_AUTONEG_RESTART];
            bc_d[BC_FULL_DUPLEX] = m[PC_FULL_DUPLEX];
            bc_d[BC_FORCE_MDIX] = m[PC_FORCE_MDIX];
            bc_d[BC_MDIX_OFF] = m[PC_MDIX_OFF];
            bc_d[BC_TX_OFF] = m[PC_TX_OFF];
            bc_d[BC_LED_OFF] = m[PC_LED_OFF];
        end
        else if (wr_fire && hit(i_address, IDX_PORT_STATUS_ALIAS))
        begin
            m = merge16(ps_view, wdata16, i_byteenable[1:0]);
            bc_d[BC_XOVER_ALG] = m[PS_XOVER_ALG];
        end
    end

    // Basic control storage.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            bc_q <= BC_RST;
        else
            bc_q <= bc_d;
    end

    // Control outputs straight from the storage flops.
    assign o_host_loopback = bc_q[BC_LOOPBACK];
    assign o_force_100 = bc_q[BC_FORCE_100];
    assign o_autoneg_en = bc_q[BC_AUTONEG_EN];
    assign o_autoneg_restart = bc_q[BC_AUTONEG_RESTART];
    assign o_full_duplex = bc_q[BC_FULL_DUPLEX];
    assign o_crossover_algorithm_select = bc_q[BC_XOVER_ALG];
    assign o_force_mdix = bc_q[BC_FORCE_MDIX];
    assign o_mdix_off = bc_q[BC_MDIX_OFF];
    assign o_tx_off = bc_q[BC_TX_OFF];
    assign o_led_off = bc_q[BC_LED_OFF];

    // Chooses what is being timed in the present state.
    always_comb
    begin
        if (state_q == ST_LOW_POWER)
        begin
            cond = i_energy_detected;
            unit_cyc = WAKE_UNIT_CYCLES;
            target = wake_time_q;
            armed = (pm_mode_q == PM_ENERGY_DETECT) & auto_wake_q;
        end
        else
        begin
            cond = ~i_energy_detected;
            unit_cyc = SLEEP_UNIT_CYCLES;
            target = sleep_time_q;
            armed = (pm_mode_q == PM_ENERGY_DETECT);
        end
        go = armed & cond & (units_q >= target);
    end

    // Counts whole units while the condition holds; any break starts over.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            prescale_q <= '0;
            units_q <= '0;
        end
        else if (!armed || !cond || go || rd_fire || wr_fire)
        begin
            prescale_q <= '0;
            units_q <= '0;
        end
        else if (prescale_q == unit_cyc - 32'h0000_0001)
        begin
            prescale_q <= '0;
            if (units_q != 8'hff)
                units_q <= units_q + 8'h01;
        end
        else
            prescale_q <= prescale_q + 32'h0000_0001;
    end

    // Power state; a host access also wakes the device from low power.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            state_q <= ST_NORMAL;
        else
        begin
            case (state_q)
                ST_NORMAL:
                    if (go)
                        state_q <= ST_LOW_POWER;
                ST_LOW_POWER:
                    if (pm_mode_q != PM_ENERGY_DETECT || rd_fire || wr_fire || go)
                        state_q <= ST_NORMAL;
                default:
                    state_q <= ST_NORMAL;
            endcase
        end
    end
    assign o_low_power = (state_q == ST_LOW_POWER);

endmodule : phy_sleep_wake_and_basic_control

// File: testbench/phy_ctrl_monitor.sv
// Checker for bus timing, control outputs, the PHY reset pulse and power timing.
// Assumes it is bound to the register bank and sees only its ports.
`timescale 1ns/1ps
module phy_ctrl_monitor
    import phy_ctrl_pkg::*;
#(
    parameter int unsigned WAKE_UNIT_CYCLES = WAKE_UNIT_CYC,
    parameter int unsigned SLEEP_UNIT_CYCLES = SLEEP_UNIT_CYC
)
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [ADDR_W-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [DATA_W-1:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    input wire logic o_waitrequest,
    input wire logic i_energy_detected,
    input wire logic o_low_power,
    input wire logic o_phy_reset,
    input wire logic [9:0] outs
);
    logic acc; // A bus access completes at this edge.
    logic wr_ctrl; // Full write to basic control.
    logic wr_rst; // Write of one to the PHY reset bit.
    logic [15:0] quiet_q; // Run of cycles without energy.
    logic [15:0] busy_q; // Run of cycles with energy.
    logic [DATA_W-1:0] wd;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    assign wd = i_writedata;
    assign acc = (i_read || i_write) && !o_waitrequest;
    assign wr_ctrl = acc && i_write && i_address == {IDX_BASIC_CTRL, 2'b00} && i_byteenable[1:0] == 2'b11;
    assign wr_rst = acc && i_write && i_address == {IDX_PHY_RESET, 2'b00} && wd[0] && i_byteenable[0];
    // Counts runs of each line condition, saturating.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            quiet_q <= '0;
            busy_q <= '0;
        end
        else
        begin
            quiet_q <= i_energy_detected ? 16'h0000 : quiet_q + {15'h0000, quiet_q != 16'hffff};
            busy_q <= !i_energy_detected ? 16'h0000 : busy_q + {15'h0000, busy_q != 16'hffff};
        end
    end
    a_wait_one_cycle: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
        else $error("waitrequest not low in second cycle");
    a_ctrl_write_out: assert property (wr_ctrl |=> outs == $past({wd[14:12], wd[9:8], wd[5:3], wd[1:0]}))
        else $error("control outputs differ from written value");
    a_ctrl_hold_out: assert property (!(acc && i_write) |=> $stable(outs))
        else $error("control outputs moved without a write");
    a_reset_pulse_fires: assert property (wr_rst |=> o_phy_reset ##1 !o_phy_reset)
        else $error("PHY reset pulse missing or too long");
    a_reset_pulse_cause: assert property (o_phy_reset |-> $past(wr_rst))
        else $error("PHY reset pulse without a write");
    a_sleep_min_quiet: assert property ($rose(o_low_power) |-> quiet_q >= SLEEP_UNIT_CYCLES)
        else $error("low power entered too early");
    a_wake_min_energy: assert property ($fell(o_low_power) |-> $past(acc) || busy_q >= WAKE_UNIT_CYCLES)
        else $error("woke too early");
    a_host_access_wake: assert property (acc && o_low_power |=> !o_low_power)
        else $error("bus access did not wake");
endmodule : phy_ctrl_monitor

bind phy_sleep_wake_and_basic_control phy_ctrl_monitor #(.WAKE_UNIT_CYCLES(WAKE_UNIT_CYCLES),
    .SLEEP_UNIT_CYCLES(SLEEP_UNIT_CYCLES)) phy_ctrl_monitor_inst (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .i_byteenable(i_byteenable), .o_waitrequest(o_waitrequest), .i_energy_detected(i_energy_detected),
    .o_low_power(o_low_power), .o_phy_reset(o_phy_reset), .outs({o_host_loopback, o_force_100,
    o_autoneg_en, o_autoneg_restart, o_full_duplex, o_crossover_algorithm_select, o_force_mdix,
    o_mdix_off, o_tx_off, o_led_off}));

// File: testbench/host_master_model.sv
// Host model: an Avalon-MM master issuing register reads and writes.
// Assumes a slave that answers through waitrequest; each wait is bounded.
`timescale 1ns/1ps
module host_master_model
    import phy_ctrl_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_waitrequest,
    input wire logic [DATA_W-1:0] i_readdata,
    output logic [ADDR_W-1:0] o_address,
    output logic o_read,
    output logic o_write,
    output logic [DATA_W-1:0] o_writedata,
    output logic [3:0] o_byteenable
);
    // The bus starts idle.
    initial
    begin
        o_address = '0;
        o_read = 1'b0;
        o_write = 1'b0;
        o_writedata = '0;
        o_byteenable = 4'h0;
    end
    // One access, held until waitrequest is sampled low; read data taken at that edge.
    task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d,
        input logic [3:0] be, output logic [REG_W-1:0] q, output logic ok);
        int n;
        @(posedge i_clk);
        o_address <= a;
        o_writedata <= {{(DATA_W-REG_W){1'b0}}, d};
        o_byteenable <= be;
        o_read <= !wr;
        o_write <= wr;
        ok = 1'b0;
        q = '0;
        for (n = 0; n < 32 && !ok; n++)
        begin
            @(posedge i_clk);
            ok = (i_waitrequest === 1'b0);
            // Read data is taken only at the edge at which waitrequest is seen low.
            if (ok)
                q = i_readdata[REG_W-1:0];
        end
        o_read <= 1'b0;
        o_write <= 1'b0;
    endtask : access
endmodule : host_master_model

// File: testbench/phy_sleep_wake_and_basic_control_tb_top.sv
// Testbench for the register bank: register rows, then power timing and reset by hand.
// Assumes timing units shortened to 4 and 8 cycles.
`timescale 1ns/1ps
module phy_sleep_wake_and_basic_control_tb_top
    import phy_ctrl_pkg::*;
;
    typedef struct packed {logic [9:0] wa; logic [15:0] wd; logic [3:0] be; logic [9:0] ra;
        logic [15:0] rd; logic [9:0] o;} row_t;
    logic clk = 1'b0, rstn, energy, read, write, wait_rq, low_power, phy_reset;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata, readdata;
    logic [3:0] byteenable;
    logic [9:0] outs; // Control outputs, bit 14 view down to bit 0 view.
    logic [15:0] q;
    int num_errors = 0, total_checks = 0, pulses = 0;
    row_t rows [10] = '{'{10'h390, 16'hffff, 4'hf, 10'h390, 16'h733b, 10'h3ff},
        '{10'h390, 16'h0000, 4'hf, 10'h3e0, 16'h0000, 10'h000},
        '{10'h3e0, 16'hc000, 4'hf, 10'h390, 16'h0003, 10'h003},
        '{10'h3e8, 16'h8000, 4'hf, 10'h390, 16'h0023, 10'h013},
        '{10'h358, 16'h0102, 4'hf, 10'h358, 16'h0102, 10'h013},
        '{10'h360, 16'h0001, 4'hf, 10'h360, 16'h0000, 10'h013},
        '{10'h3f0, 16'hffff, 4'hf, 10'h3f0, 16'h0000, 10'h013},
        '{10'h390, 16'h3120, 4'hf, 10'h390, 16'h3120, 10'h1b0},
        '{10'h390, 16'hffff, 4'h1, 10'h390, 16'h313b, 10'h1bf},
        '{10'h390, 16'h0000, 4'h0, 10'h390, 16'h313b, 10'h1bf}};
    always #2 clk = ~clk;
    // Counts cycles with the PHY reset pulse high.
    always @(posedge clk)
    begin
        if (phy_reset === 1'b1)
            pulses++;
    end
    phy_sleep_wake_and_basic_control #(.WAKE_UNIT_CYCLES(4), .SLEEP_UNIT_CYCLES(8))
        phy_sleep_wake_and_basic_control_inst (.i_clk(clk), .i_rstn(rstn), .i_address(address),
        .i_read(read), .i_write(write), .i_writedata(writedata), .i_byteenable(byteenable),
        .o_readdata(readdata), .o_waitrequest(wait_rq), .i_energy_detected(energy), .o_low_power(low_power),
        .o_phy_reset(phy_reset), .o_host_loopback(outs[9]), .o_force_100(outs[8]), .o_autoneg_en(outs[7]),
        .o_autoneg_restart(outs[6]), .o_full_duplex(outs[5]), .o_crossover_algorithm_select(outs[4]),
        .o_force_mdix(outs[3]), .o_mdix_off(outs[2]), .o_tx_off(outs[1]), .o_led_off(outs[0]));
    host_master_model host_master_model_inst (.i_clk(clk), .i_waitrequest(wait_rq), .i_readdata(readdata),
        .o_address(address), .o_read(read), .o_write(write), .o_writedata(writedata),
        .o_byteenable(byteenable));
    // Compares and counts; a mismatch is reported at once.
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Prints the counts and the verdict, then stops.
    task automatic conclude();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude
    // One bus access; a timeout ends the run.
    task automatic bus(input logic wr, input logic [9:0] a, input logic [15:0] d, output logic [15:0] r,
        input logic [3:0] be = 4'hf);
        logic ok;
        host_master_model_inst.access(wr, a, d, be, r, ok);
        check({15'h0000, ok}, 16'h0001);
        if (ok !== 1'b1)
            conclude();
    endtask : bus
    // Waits a bounded time for low_power to reach a level, then checks whether it did.
    task automatic wait_lp(input logic lvl, input int lim, input logic exp);
        int n;
        logic hit;
        hit = 1'b0;
        for (n = 0; n < lim && !hit; n++)
        begin
            @(posedge clk);
            hit = (low_power === lvl);
        end
        check({15'h0000, hit}, {15'h0000, exp});
    endtask : wait_lp
    // Main sequence: reset values, the row table, then power timing and a second reset.
    initial
    begin
        rstn = 1'b0;
        energy = 1'b0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        bus(0, 10'h390, 16'h0000, q);
        check(q, 16'h3120);
        check({6'h00, outs}, 16'h01b0);
        bus(0, 10'h358, 16'h0000, q);
        check(q, 16'h080c);
        $display("test reset values done");
        foreach (rows[i])
        begin
            bus(1, rows[i].wa, rows[i].wd, q, rows[i].be);
            bus(0, rows[i].ra, 16'h0000, q);
            check(q, rows[i].rd);
            check({6'h00, outs}, {6'h00, rows[i].o});
        end
        check(pulses[15:0], 16'h0001);
        $display("test register rows done");
        bus(1, 10'h358, 16'h0101, q);
        bus(1, 10'h350, 16'h0001, q);
        repeat (8)
        begin
            @(posedge clk);
            energy <= 1'b1;
            @(posedge clk);
            energy <= 1'b0;
            repeat (5) @(posedge clk);
        end
        check({15'h0000, low_power}, 16'h0000);
        wait_lp(1, 40, 1);
        energy <= 1'b1;
        wait_lp(0, 40, 0);
        bus(1, 10'h350, 16'h0081, q);
        // The wake takes effect at the edge that completes the write, so look one edge later.
        @(posedge clk);
        check({15'h0000, low_power}, 16'h0000);
        energy <= 1'b0;
        wait_lp(1, 40, 1);
        energy <= 1'b1;
        wait_lp(0, 20, 1);
        bus(1, 10'h350, 16'h0080, q);
        energy <= 1'b0;
        wait_lp(1, 40, 0);
        $display("test power timing done");
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        bus(0, 10'h390, 16'h0000, q);
        check(q, 16'h3120);
        check({6'h00, outs}, 16'h01b0);
        $display("test second reset done");
        conclude();
    end
endmodule : phy_sleep_wake_and_basic_control_tb_top
